// ---- verification/ifs_mem_model.sv ----
// behavioural delay-line memory behind the channel gates
// assumes the gate opens at character count 0 and stays for a minor cycle
`timescale 1ns/10ps
module ifs_mem_model
(
  input wire logic i_mclk,
  input wire logic [ifs_pkg::CHANNELS-1:0] i_gate,
  input wire logic [ifs_pkg::WORD_W-1:0] i_word,
  input wire logic i_bad_parity,
  output logic [ifs_pkg::CHAR_W-1:0] o_char
);
  import ifs_pkg::*;
  logic [3:0] pos_cnt = 4'h0;
  logic [CHAR_W-1:0] last_char = 7'h55;
  logic [CHAR_W-1:0] cur_char;
  // lockstep slots: one word serves any channel; position 12 leaves first
  assign cur_char = i_word[pos_cnt*CHAR_W +: CHAR_W] ^ {6'h00, i_bad_parity};
  // character index within the open gate
  always_ff @(posedge i_mclk)
  begin
    pos_cnt <= (|i_gate) ? pos_cnt + 4'h1 : 4'h0;
    if (|i_gate)
      last_char <= cur_char;
  end
  // closed gate shows no stale word, so a late sample cannot pass by luck
  assign o_char = (|i_gate) ? cur_char : ~last_char;
endmodule

// ---- verification/ifs_sequencer_sva.sv ----
// assertions on the fetch sequencer top ports
// assumes one clock i_mclk and async active-low i_rst_n
`timescale 1ns/10ps
module ifs_sequencer_sva
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_exec_done,
  input wire logic i_restart,
  input wire logic [ifs_pkg::CHANNELS-1:0] o_chan_gate,
  input wire logic [1:0] o_stage,
  input wire logic o_wait,
  input wire logic o_decode,
  input wire logic o_execute,
  input wire logic o_halted
);
  import ifs_pkg::*;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  logic gate_any;
  // any channel gate open
  assign gate_any = |o_chan_gate;
  a_stage_order: assert property ($changed(o_stage) |-> o_stage == $past(o_stage) + 2'h1)
    else $error("stage counter left its order");
  a_wait_opens: assert property ($changed(o_stage) |-> o_wait)
    else $error("stage opened without wait");
  a_wait_length: assert property ($rose(o_wait) |-> o_wait [*8] ##1 o_wait [*4])
    else $error("wait shorter than a minor cycle");
  a_gate_one_hot: assert property (gate_any |-> $onehot(o_chan_gate) && o_stage == 2'h1)
    else $error("gate not one channel in second stage");
  a_gate_width: assert property ($rose(gate_any) |-> gate_any [*8] ##1 gate_any [*4] ##1 !gate_any)
    else $error("gate not one minor cycle");
  a_match_steps: assert property ($fell(gate_any) |-> o_stage == 2'h2 && o_wait)
    else $error("match end did not enter third stage");
  a_exec_qual: assert property (o_execute |-> o_stage[1] && !o_wait && !o_halted)
    else $error("execute outside its stages");
  a_decode_qual: assert property (o_decode |-> o_stage[1] && o_wait)
    else $error("decode outside wait");
  a_wrap_first: assert property (o_execute && i_exec_done && o_stage == 2'h3 |->
    ##[1:12] (o_stage == 2'h0 && o_wait))
    else $error("fourth stage did not wrap");
  a_halt_holds: assert property (o_halted && !i_restart && !i_wr |=> $stable(o_stage) && o_wait)
    else $error("halted sequencer moved");
  c_match: cover property ($rose(gate_any));
  c_exec: cover property (o_execute && i_exec_done);
  c_halt: cover property ($rose(o_halted));
endmodule

bind ifs_sequencer ifs_sequencer_sva u_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr(i_wr),
  .i_exec_done(i_exec_done), .i_restart(i_restart), .o_chan_gate(o_chan_gate),
  .o_stage(o_stage), .o_wait(o_wait), .o_decode(o_decode), .o_execute(o_execute),
  .o_halted(o_halted));

// ---- verification/ifs_sequencer_tb.sv ----
// self-checking bench for the fetch sequencer
// assumes the memory model above and a bench-driven execution decoder
`timescale 1ns/10ps
module ifs_sequencer_tb;
  import ifs_pkg::*;
  logic i_mclk, i_rst_n, i_wr, i_rd, i_overflow, i_exec_done, i_restart, bad_par;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic [CHAR_W-1:0] i_mem_char;
  logic [CHANNELS-1:0] o_chan_gate;
  logic [3:0] o_slot_sel;
  logic [1:0] o_stage;
  logic o_wait, o_decode, o_execute, o_halted;
  logic [HALF_W-1:0] o_instr;
  logic [WORD_W-1:0] mem_word;
  int fail_count = 0;
  int checks_done = 0;

  ifs_sequencer u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mem_char(i_mem_char),
    .o_chan_gate(o_chan_gate), .o_slot_sel(o_slot_sel), .i_overflow(i_overflow),
    .i_exec_done(i_exec_done), .i_restart(i_restart), .o_stage(o_stage), .o_wait(o_wait),
    .o_decode(o_decode), .o_execute(o_execute), .o_instr(o_instr), .o_halted(o_halted));
  ifs_mem_model u_mem (.i_mclk(i_mclk), .i_gate(o_chan_gate), .i_word(mem_word),
    .i_bad_parity(bad_par), .o_char(i_mem_char));

  // free-running 200 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [CHANNELS-1:0] seen,
    input logic [CHANNELS-1:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // digits p mod 10 with odd check bit, position 1 in the top character
  function automatic logic [WORD_W-1:0] make_word();
    logic [WORD_W-1:0] w;
    logic [3:0] d;
    for (int p = 1; p <= CHARS_PER_WORD; p++)
    begin
      d = 4'(p % 10);
      w[(CHARS_PER_WORD-p)*CHAR_W +: CHAR_W] = {~^d, ZONE_DIGIT, d};
    end
    return w;
  endfunction

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // read data are judged only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(what, o_rdata, exp);
  endtask

  // one status bit; the rest of the word moves with the timing
  task automatic bus_rd_bit(input logic [7:0] a, input int b, input logic exp, input string what);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(what, o_rdata[b], exp);
  endtask

  function automatic logic cond(input int k, input logic [1:0] st);
    case (k)
      0: return o_stage === st && o_wait === 1'b1;
      1: return (|o_chan_gate) === 1'b1;
      2: return o_execute === 1'b1 && o_stage === st;
      default: return o_halted === 1'b1;
    endcase
  endfunction

  // bounded wait; a miss ends the run
  task automatic wait_for(input int k, input logic [1:0] st);
    int n;
    n = 0;
    do
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    while (!cond(k, st) && n < 400);
    if (!cond(k, st))
    begin
      fail_count++;
      $display("Error wait %0d expected 1 seen 0", k);
      final_report();
    end
  endtask

  task automatic done_pulse(input logic ovf);
    @(posedge i_mclk);
    i_exec_done <= 1'b1;
    i_overflow <= ovf;
    @(posedge i_mclk);
    i_exec_done <= 1'b0;
    i_overflow <= 1'b0;
  endtask

  task automatic t_regs();
    bus_rd(REG_STATUS, 32'h0000_0004, "status");
    bus_rd(8'h0C, 32'h0, "unmapped");
    bus_wr(8'h0C, 32'hFFFF_FFFF);
    bus_rd(8'h0C, 32'h0, "unmapped");
    bus_rd(REG_CTRL, 32'h0, "ctrl");
    bus_wr(REG_CTRL, 32'h0000_0001);
    bus_rd(REG_CTRL, 32'h0000_0001, "ctrl");
  endtask

  // one full alpha to delta cycle
  task automatic t_fetch(input logic [3:0] slot, input logic ovf, input logic [11:0] ploc);
    wait_for(0, 2'h1);
    wait_for(1, 2'h1);
    chk("slot", o_slot_sel, slot);
    chk("gate", o_chan_gate, 100'h1);
    wait_for(0, 2'h2);
    repeat (2) @(posedge i_mclk);
    #1;
    chk("decode", o_decode, 1'b1);
    chk("left", o_instr, mem_word[WORD_W-1:HALF_W]);
    bus_rd_bit(REG_STATUS, ST_NEG, mem_word[WORD_W-1 -: CHAR_W] == MINUS_CHAR, "sign");
    wait_for(2, 2'h2);
    done_pulse(1'b0);
    #1;
    chk("exec off", o_execute, 1'b0);
    wait_for(0, 2'h3);
    repeat (2) @(posedge i_mclk);
    #1;
    chk("right", o_instr, mem_word[HALF_W-1:0]);
    wait_for(2, 2'h3);
    done_pulse(ovf);
    wait_for(0, 2'h0);
    bus_rd(REG_PLOC, {20'h0, ploc}, "ploc");
  endtask

  task automatic t_parity();
    @(posedge i_mclk);
    bad_par <= 1'b1;
    wait_for(1, 2'h1);
    wait_for(3, 2'h0);
    chk("halt stage", o_stage, 2'h2);
    chk("halt wait", o_wait, 1'b1);
    @(posedge i_mclk);
    bad_par <= 1'b0;
    repeat (40) @(posedge i_mclk);
    #1;
    chk("held stage", o_stage, 2'h2);
    @(posedge i_mclk);
    i_restart <= 1'b1;
    @(posedge i_mclk);
    i_restart <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("restart", o_halted, 1'b0);
  endtask

  // main sequence
  initial
  begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_overflow = 1'b0;
    i_exec_done = 1'b0;
    i_restart = 1'b0;
    bad_par = 1'b0;
    mem_word = make_word();
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_regs();
    t_fetch(4'h0, 1'b0, 12'h001);
    t_fetch(4'h1, 1'b1, 12'h002);
    t_fetch(4'h0, 1'b0, 12'h002);
    mem_word[WORD_W-1 -: CHAR_W] <= MINUS_CHAR;
    t_fetch(4'h2, 1'b0, 12'h003);
    t_parity();
    final_report();
  end
endmodule

// ---- verilog/ifs_parity_chk.sv ----
// odd-parity checker for one character on the transfer bus
// assumes a whole character is presented in parallel each clock
`timescale 1ns/10ps
module ifs_parity_chk
(
  input wire logic [ifs_pkg::CHAR_W-1:0] i_char,
  output logic o_odd
);
  import ifs_pkg::*;

  // a valid character always holds an odd number of ones
  assign o_odd = ^i_char;
endmodule

// ---- verilog/ifs_pkg.sv ----
// shared constants and types of the instruction fetch sequencer
// assumes a 200 MHz clock; one character moves per clock edge
package ifs_pkg;
  localparam int CHAR_W = 7;
  localparam int CHARS_PER_WORD = 12;
  localparam int WORD_W = CHAR_W * CHARS_PER_WORD;
  localparam int HALF_W = WORD_W / 2;
  localparam int SLOTS = 10;
  localparam int CHANNELS = 100;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // character field layout: numeric bits, zone bits, check bit
  localparam int NUM_LSB = 0;
  localparam int ZONE_LSB = 4;
  localparam int CHECK_BIT = 6;
  localparam logic [1:0] ZONE_DIGIT = 2'h0;
  // sign character of a negative word; code is an arbitrary choice,
  // with an odd count of ones so a negative word passes the bus check
  localparam logic [6:0] MINUS_CHAR = 7'h4C;
  // timing: minor cycle is one word time of character slots
  localparam logic [3:0] CHAR_LAST = 4'hB;
  localparam logic [3:0] SLOT_LAST = 4'h9;
  localparam real CLK_NS = 5.0;
  localparam real MINOR_NS = 60.0;
  localparam int MINOR_CYCLES = int'(MINOR_NS / CLK_NS);
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PLOC = 8'h08;
  // control fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_RESTART = 1;
  localparam logic CTRL_RUN_RESET = 1'b0;
  // status fields
  localparam int ST_STAGE_LSB = 0;
  localparam int ST_WAIT = 2;
  localparam int ST_HALTED = 3;
  localparam int ST_PERR = 4;
  localparam int ST_OVF = 5;
  localparam int ST_MATCH = 6;
  localparam int ST_NEG = 7;
  localparam int ST_SLOT_LSB = 8;
  localparam logic [11:0] PLOC_RESET = 12'h000;
  typedef enum logic [1:0] {IFS_ALPHA, IFS_BETA, IFS_GAMMA, IFS_DELTA} ifs_stage_e;
endpackage

// ---- verilog/ifs_sequencer.sv ----
// four-stage fetch sequencer core with register port
// assumes memory answers i_mem_char in the same clock as the gate opens;
// the execution decoder pulses i_exec_done once per executed instruction.
// Summary of operation
// - two-bit stage counter, fixed order, wraps
// - each stage opens with a wait, one minor cycle while run is set
// - first stage latches location positions 7-12
// - even character parity halts at next wait
// - seven-bit characters, twelve per word
// - position 1 is the sign
// - hundred channels of ten lockstep word slots
// - position 12 first; numeric, zone, check order
// - slot counter steps per minor cycle, modulo ten
// - second stage compares slot with latch digit
// - digits four and five pick one channel
// - second stage waits until slot matches
// - match cycle loads pair, adds one
// - match end steps to third stage, sets wait
// - second-stage end latches left instruction
// - location holds only three decimal digits
// - third stage decodes, executes, latches right
// - fourth stage executes, returns to first
// - overflow loads zeros into latch next
// - overflow suppresses next location increment
`timescale 1ns/10ps
module ifs_sequencer
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [ifs_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ifs_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ifs_pkg::DATA_W-1:0] o_rdata,
  input wire logic [ifs_pkg::CHAR_W-1:0] i_mem_char,
  output logic [ifs_pkg::CHANNELS-1:0] o_chan_gate,
  output logic [3:0] o_slot_sel,
  input wire logic i_overflow,
  input wire logic i_exec_done,
  input wire logic i_restart,
  output logic [1:0] o_stage,
  output logic o_wait,
  output logic o_decode,
  output logic o_execute,
  output logic [ifs_pkg::HALF_W-1:0] o_instr,
  output logic o_halted
);
  import ifs_pkg::*;

  typedef struct packed
  {
    ifs_stage_e stage;
    logic wait_interval;
    logic halted;
    logic perr;
    logic ovf;
    logic slot_match_flag;
    logic run;
    logic done_pend;
    logic [11:0] program_location_register;
    logic [WORD_W-1:0] instruction_pair_register;
    logic [HALF_W-1:0] static_instruction_latch;
    logic [CHANNELS-1:0] chan_gate;
    logic [3:0] slot_sel;
    logic decode;
    logic execute;
    logic [DATA_W-1:0] rdata;
  } ifs_core_s;

  ifs_core_s st;
  ifs_core_s next_st;
  ifs_timing_if tmg ();
  logic [CHAR_W-1:0] main_transfer_bus;
  logic bus_active;
  logic bus_odd;
  logic [3:0] slot_next;
  logic restart;
  logic [6:0] chan_idx;

  ifs_timing_gen u_timing_generator
  (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .tmg(tmg)
  );

  ifs_parity_chk u_bus_parity_checker
  (
    .i_char(main_transfer_bus),
    .o_odd(bus_odd)
  );

  // a decimal digit as a bus character with odd check bit
  function automatic logic [CHAR_W-1:0] digit_char(input logic [3:0] d);
    logic [5:0] body;
    body = {ZONE_DIGIT, d};
    digit_char = {~(^body), body};
  endfunction

  // three-digit decimal increment; wraps 999 to 000
  function automatic logic [11:0] bcd_inc(input logic [11:0] v);
    logic [11:0] r;
    r = v;
    if (v[3:0] != 4'h9)
      r[3:0] = v[3:0] + 4'h1;
    else
    begin
      r[3:0] = 4'h0;
      if (v[7:4] != 4'h9)
        r[7:4] = v[7:4] + 4'h1;
      else
      begin
        r[7:4] = 4'h0;
        r[11:8] = (v[11:8] != 4'h9) ? v[11:8] + 4'h1 : 4'h0;
      end
    end
    bcd_inc = r;
  endfunction

  // location word is nine zero digits then three address digits
  function automatic logic [CHAR_W-1:0] ploc_char(input logic [11:0] pl,
                                                   input logic [3:0] cnt);
    logic [3:0] d;
    d = 4'h0;
    if (cnt == 4'h0)
      d = pl[3:0];
    else if (cnt == 4'h1)
      d = pl[7:4];
    else if (cnt == 4'h2)
      d = pl[11:8];
    ploc_char = digit_char(d);
  endfunction

  // channel index from instruction digits four (tens) and five (ones)
  function automatic logic [6:0] chan_of(input logic [HALF_W-1:0] lat);
    logic [6:0] tens;
    logic [6:0] ones;
    tens = {3'h0, lat[2*CHAR_W+NUM_LSB +: 4]};
    ones = {3'h0, lat[CHAR_W+NUM_LSB +: 4]};
    chan_of = 7'(tens * 7'd10 + ones);
  endfunction

  // slot of the coming minor cycle: the match flag is set one cycle ahead
  assign slot_next = (tmg.slot == SLOT_LAST) ? 4'h0 : tmg.slot + 4'h1;
  assign restart = i_restart || (i_wr && i_addr == REG_CTRL && i_wdata[CTRL_RESTART]);
  // the latch never moves while a gate is open, so the registered copy
  // serves and keeps the gate decode out of its own fan-in
  assign chan_idx = chan_of(st.static_instruction_latch);

  // bus source: location word in first stage, memory in the match cycle
  always_comb
  begin
    bus_active = 1'b0;
    main_transfer_bus = '0;
    if (!st.halted && !st.wait_interval)
    begin
      if (st.stage == IFS_ALPHA)
      begin
        bus_active = 1'b1;
        main_transfer_bus = ploc_char(st.program_location_register, tmg.char_cnt);
      end
      else if (st.stage == IFS_BETA && st.slot_match_flag)
      begin
        bus_active = 1'b1;
        main_transfer_bus = i_mem_char;
      end
    end
  end

  // sequencing, flags and register port
  always_comb
  begin
    next_st = st;
    // overflow is sticky until the next second stage has used it
    if (i_overflow)
      next_st.ovf = 1'b1;
    // restart clears the halt; a fresh error in the same cycle still wins
    if (restart)
    begin
      next_st.halted = 1'b0;
      next_st.perr = 1'b0;
    end
    if (bus_active && !bus_odd)
      next_st.perr = 1'b1;
    // every bus character lands in the pair register at its own position
    if (bus_active)
      next_st.instruction_pair_register[7*int'(tmg.char_cnt) +: CHAR_W] = main_transfer_bus;
    // a halted machine freezes stage and wait until a restart arrives
    if (!st.halted)
    begin
      // comparison runs in the wait and every later minor cycle;
      // a match seen for the wait cycle itself is dropped, since the gate
      // only opens outside a wait: the worst case is ten cycles after it
      if (st.stage == IFS_BETA && tmg.minor_end && !(st.slot_match_flag && !st.wait_interval))
        next_st.slot_match_flag = (slot_next == st.static_instruction_latch[3:0]);
      if (st.wait_interval)
      begin
        // a wait lasts one minor cycle while run is set; a pending error halts here instead
        if (tmg.minor_end)
        begin
          if (st.perr)
            next_st.halted = 1'b1;
          else if (st.run)
            next_st.wait_interval = 1'b0;
        end
      end
      else
      begin
        unique case (st.stage)
          IFS_ALPHA:
          begin
            if (tmg.minor_end)
            begin
              // overflow forces the next pair to come from location 000
              if (st.ovf)
                next_st.static_instruction_latch = '0;
              else
                next_st.static_instruction_latch =
                  next_st.instruction_pair_register[HALF_W-1:0];
              next_st.stage = IFS_BETA;
              next_st.wait_interval = 1'b1;
              next_st.slot_match_flag =
                (slot_next == next_st.static_instruction_latch[3:0]);
            end
          end
          IFS_BETA:
          begin
            // stay here until the slot comes round
            if (tmg.minor_end && st.slot_match_flag)
            begin
              next_st.static_instruction_latch =
                next_st.instruction_pair_register[WORD_W-1:HALF_W];
              if (!st.ovf)
                next_st.program_location_register =
                  bcd_inc(st.program_location_register);
              next_st.ovf = i_overflow;
              next_st.slot_match_flag = 1'b0;
              next_st.stage = IFS_GAMMA;
              next_st.wait_interval = 1'b1;
            end
          end
          IFS_GAMMA:
          begin
            // done is held until the minor-cycle boundary, so the next wait
            // is a whole minor cycle wherever the decoder finishes
            if (i_exec_done)
              next_st.done_pend = 1'b1;
            if (tmg.minor_end && next_st.done_pend)
            begin
              next_st.static_instruction_latch =
                st.instruction_pair_register[HALF_W-1:0];
              next_st.done_pend = 1'b0;
              next_st.stage = IFS_DELTA;
              next_st.wait_interval = 1'b1;
            end
          end
          IFS_DELTA:
          begin
            // same boundary rule as the third stage
            if (i_exec_done)
              next_st.done_pend = 1'b1;
            if (tmg.minor_end && next_st.done_pend)
            begin
              next_st.done_pend = 1'b0;
              next_st.stage = IFS_ALPHA;
              next_st.wait_interval = 1'b1;
            end
          end
        endcase
      end
    end
    // register writes
    // a location write lands over any increment of the same cycle
    if (i_wr && i_addr == REG_CTRL)
      next_st.run = i_wdata[CTRL_RUN];
    if (i_wr && i_addr == REG_PLOC)
      next_st.program_location_register = i_wdata[11:0];
    // read data stand only in the cycle after the strobe
    next_st.rdata = '0;
    if (i_rd)
    begin
      if (i_addr == REG_CTRL)
        next_st.rdata[CTRL_RUN] = st.run;
      else if (i_addr == REG_PLOC)
        next_st.rdata[11:0] = st.program_location_register;
      else if (i_addr == REG_STATUS)
      begin
        next_st.rdata[ST_STAGE_LSB +: 2] = st.stage;
        next_st.rdata[ST_WAIT] = st.wait_interval;
        next_st.rdata[ST_HALTED] = st.halted;
        next_st.rdata[ST_PERR] = st.perr;
        next_st.rdata[ST_OVF] = st.ovf;
        next_st.rdata[ST_MATCH] = st.slot_match_flag;
        // sign lives in position 1 of the fetched word
        next_st.rdata[ST_NEG] =
          (st.instruction_pair_register[WORD_W-1 -: CHAR_W] == MINUS_CHAR);
        next_st.rdata[ST_SLOT_LSB +: 4] = tmg.slot;
      end
    end
    // outputs registered from the coming state so they line up with it
    next_st.chan_gate = '0;
    next_st.slot_sel = next_st.static_instruction_latch[3:0];
    if (next_st.stage == IFS_BETA && next_st.slot_match_flag && !next_st.wait_interval
        && !next_st.halted)
      next_st.chan_gate = {{(CHANNELS-1){1'b0}}, 1'b1} << chan_idx;
    next_st.decode = (next_st.stage == IFS_GAMMA || next_st.stage == IFS_DELTA)
                     && next_st.wait_interval;
    // execute drops once the decoder reports done, though the stage itself
    // moves only at the minor-cycle boundary
    next_st.execute = (next_st.stage == IFS_GAMMA || next_st.stage == IFS_DELTA)
                      && !next_st.wait_interval && !next_st.halted && !next_st.done_pend;
  end

  // halted state freezes stage and wait until restart
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
      st.stage <= IFS_ALPHA;
      st.wait_interval <= 1'b1;
      st.run <= CTRL_RUN_RESET;
      st.program_location_register <= PLOC_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // every output is a register bit with no logic behind it
  assign o_rdata = st.rdata;
  assign o_chan_gate = st.chan_gate;
  assign o_slot_sel = st.slot_sel;
  assign o_stage = st.stage;
  assign o_wait = st.wait_interval;
  assign o_decode = st.decode;
  assign o_execute = st.execute;
  assign o_instr = st.static_instruction_latch;
  assign o_halted = st.halted;
endmodule

// ---- verilog/ifs_timing_gen.sv ----
// timing generator: character counter and word slot counter
// assumes i_mclk and async active-low reset shared with the core
`timescale 1ns/10ps
module ifs_timing_gen
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  ifs_timing_if.gen tmg
);
  import ifs_pkg::*;

  typedef struct packed
  {
    logic [3:0] char_cnt;
    logic [3:0] slot;
  } ifs_tg_s;

  ifs_tg_s st;
  ifs_tg_s next_st;

  // slot advances once per minor cycle, modulo ten
  always_comb
  begin
    next_st = st;
    if (st.char_cnt == CHAR_LAST)
    begin
      next_st.char_cnt = 4'h0;
      next_st.slot = (st.slot == SLOT_LAST) ? 4'h0 : st.slot + 4'h1;
    end
    else
    begin
      next_st.char_cnt = st.char_cnt + 4'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  // count 0 carries position 12, count 11 carries position 1
  assign tmg.char_cnt = st.char_cnt;
  assign tmg.slot = st.slot;
  assign tmg.minor_end = (st.char_cnt == CHAR_LAST);
endmodule

// ---- verilog/ifs_timing_if.sv ----
// carrier between the timing generator and the sequencer core
// assumes both ends share i_mclk
`timescale 1ns/10ps
interface ifs_timing_if;
  logic [3:0] char_cnt;
  logic [3:0] slot;
  logic minor_end;
  modport gen (output char_cnt, output slot, output minor_end);
  modport seq (input char_cnt, input slot, input minor_end);
endinterface
